// file: design/dar_top.sv
// DRAM address multiplexer, strobe select and refresh scheduler.
// Assumes a single 25 MHz clock; strobes here are active high requests,
// the pad ring inverts them to the DRAM's active-low pins.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "dar_regs.svh"
module dar_top
   import dar_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // Access request from the memory sequencer
   input  wire logic        acc_req,
   input  wire logic [25:0] acc_addr,
   input  wire logic [15:0] acc_bytes,
   input  wire logic [1:0]  acc_bank,
   input  wire logic        acc_sub,
   // Arbiter and watchdog
   input  wire logic        refresh_grant,
   output logic             refresh_req,
   output logic             start_refresh,
   output logic             wdog_inc,
   // DRAM side
   output logic [11:0]      mem_addr,
   output logic [7:0]       ras_on,
   output logic [15:0]      cas_on,
   output logic             refresh_busy
);
   logic [15:0] preload_reg;
   logic [15:0] count_reg;
   logic [3:0]  rows_reg;
   logic [15:0] timing_reg;
   logic [3:0]  two_sub_reg;
   logic        rollover;
   logic        grant_s1_reg;
   logic        grant_s2_reg;
   logic        start_reg;
   logic        cyc_ras_a;
   logic        cyc_ras_b;
   logic        cyc_cas;
   logic        cyc_busy;
   dar_phase_type phase_reg;
   logic [1:0]  acc_cnt_reg;
   logic [25:0] addr_reg;
   logic [1:0]  bank_reg;
   logic        sub_reg;
   logic [15:0] bytes_reg;

   // Row and column pin maps
   function automatic logic [11:0] row_map(input logic [25:0] a);
      row_map = {a[24], a[25], a[22:13]};                          // [R1]
   endfunction : row_map
   function automatic logic [11:0] col_map(input logic [25:0] a);
      col_map = {a[24], a[24], a[23], a[12:4]};                    // [R2]
   endfunction : col_map

   // Registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         preload_reg <= `DAR_PRELOAD_RST;
         rows_reg    <= `DAR_ROWS_RST;
         timing_reg  <= {`DAR_PRECH_RST, `DAR_RASCAS_RST, `DAR_CASLOW_RST,
                         `DAR_LEAD_RST};
         two_sub_reg <= 4'h0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `DAR_ADDR_PRELOAD: preload_reg <= reg_wdata[15:0];     // [R7]
            `DAR_ADDR_BURST:   rows_reg    <= reg_wdata[3:0];      // [R8]
            `DAR_ADDR_TIMING:  timing_reg  <= reg_wdata[15:0];
            `DAR_ADDR_BANKCFG: two_sub_reg <= reg_wdata[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) reg_rdata <= 32'h0000_0000;
      else if (reg_rd) begin
         unique case (reg_addr)
            `DAR_ADDR_PRELOAD: reg_rdata <= {16'h0000, preload_reg};
            `DAR_ADDR_BURST:   reg_rdata <= {28'h0000000, rows_reg};
            `DAR_ADDR_TIMING:  reg_rdata <= {16'h0000, timing_reg};
            `DAR_ADDR_BANKCFG: reg_rdata <= {28'h0000000, two_sub_reg};
            `DAR_ADDR_STATUS:  reg_rdata <= {29'h0, cyc_busy, refresh_busy,
                                             refresh_req};
            `DAR_ADDR_COUNT:   reg_rdata <= {16'h0000, count_reg};
            default:           reg_rdata <= 32'h0000_0000;
         endcase
      end else reg_rdata <= 32'h0000_0000;
   end

   // Refresh interval counter
   assign rollover = (count_reg == 16'h0000);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) count_reg <= `DAR_PRELOAD_RST;
      else if (rollover) count_reg <= preload_reg;                 // [R10]
      else count_reg <= count_reg - 16'h0001;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) wdog_inc <= 1'b0;
      else wdog_inc <= rollover;                                   // [R14]
   end

   // Grant comes from the arbiter's domain, so it is synchronised
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         grant_s1_reg <= 1'b0;
         grant_s2_reg <= 1'b0;
      end else begin
         grant_s1_reg <= refresh_grant;
         grant_s2_reg <= grant_s1_reg;
      end
   end

   // A rollover during a pending request is absorbed: one burst serves it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) refresh_req <= 1'b0;
      else if (rollover) refresh_req <= 1'b1;                      // [R11]
      else if (start_reg) refresh_req <= 1'b0;                     // [R19]
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) start_reg <= 1'b0;
      else start_reg <= refresh_req && grant_s2_reg && !start_reg
                        && !cyc_busy && !refresh_busy;             // [R12]
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         start_refresh <= 1'b0;
         refresh_busy  <= 1'b0;
      end else begin
         start_refresh <= start_reg;
         refresh_busy  <= cyc_busy || start_reg;
      end
   end

   dar_cycle u_cycle (
      .clk                       (clk),
      .rstn                      (rstn),
      .start                     (start_reg),
      .rows                      (rows_reg),                       // [R13]
      .cas_lead_cycles           (timing_reg[`DAR_TIM_LEAD_LSB +: 4]),
      .refresh_cas_low_cycles    (timing_reg[`DAR_TIM_CASLOW_LSB +: 4]),
      .refresh_ras_to_cas_cycles (timing_reg[`DAR_TIM_RASCAS_LSB +: 4]),
      .precharge_cycles          (timing_reg[`DAR_TIM_PRECH_LSB +: 4]),
      .ras_a_reg                 (cyc_ras_a),
      .ras_b_reg                 (cyc_ras_b),
      .cas_reg                   (cyc_cas),
      .busy_reg                  (cyc_busy)
   );

   // Normal access: row address, row strobe a cycle later, then column
   // address with column strobe two cycles after it. Refresh wins.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase_reg   <= DAR_PH_IDLE;
         acc_cnt_reg <= 2'h0;
         addr_reg    <= 26'h0000000;
         bank_reg    <= 2'h0;
         sub_reg     <= 1'b0;
         bytes_reg   <= 16'h0000;
      end else begin
         unique case (phase_reg)
            DAR_PH_IDLE: if (acc_req && !cyc_busy && !start_reg) begin
               phase_reg   <= DAR_PH_ROW;
               acc_cnt_reg <= 2'h0;
               addr_reg    <= acc_addr;
               bank_reg    <= acc_bank;
               sub_reg     <= acc_sub;
               bytes_reg   <= acc_bytes;
            end
            DAR_PH_ROW: begin
               acc_cnt_reg <= acc_cnt_reg + 2'h1;
               if (acc_cnt_reg == 2'h3) phase_reg <= DAR_PH_IDLE;
            end
            default: phase_reg <= DAR_PH_IDLE;
         endcase
      end
   end

   // Cycle 0 row addr, 1 row strobe + column addr, 3 column strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_addr <= 12'h000;
         ras_on   <= 8'h00;
         cas_on   <= 16'h0000;
      end else if (cyc_busy) begin
         mem_addr <= 12'h000;                                      // [R6]
         ras_on   <= {cyc_ras_b, cyc_ras_a, cyc_ras_b, cyc_ras_a,
                      cyc_ras_b, cyc_ras_a, cyc_ras_b, cyc_ras_a}; // [R9]
         cas_on   <= {16{cyc_cas}};
      end else if (phase_reg == DAR_PH_ROW) begin
         mem_addr <= (acc_cnt_reg == 2'h0) ? row_map(addr_reg)
                                           : col_map(addr_reg);
         ras_on   <= 8'h00;
         // Odd strobe only when the bank is built from two subbanks
         ras_on[{bank_reg, sub_reg && two_sub_reg[bank_reg]}] <=
            (acc_cnt_reg != 2'h0);                                 // [R4] [R5] [R15]
         cas_on   <= (acc_cnt_reg == 2'h3) ? bytes_reg : 16'h0000; // [R3]
      end else begin
         ras_on <= 8'h00;
         cas_on <= 16'h0000;
      end
   end

   wdog_pulse_a: assert property (@(posedge clk) disable iff (!rstn)  // [R14]
      rollover |=> wdog_inc ##1 !wdog_inc)
      else $error("watchdog pulse missing or long");
   req_raise_a: assert property (@(posedge clk) disable iff (!rstn)   // [R11]
      rollover |=> refresh_req)
      else $error("rollover did not raise request");
   start_grant_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
      $rose(start_refresh) |-> $past(grant_s2_reg, 2))
      else $error("start without grant");
   req_drop_a: assert property (@(posedge clk) disable iff (!rstn)    // [R19]
      start_reg && !rollover |=> !refresh_req)
      else $error("request kept after start");
   reload_a: assert property (@(posedge clk) disable iff (!rstn)      // [R10]
      rollover && !reg_wr |=> count_reg == $past(preload_reg))
      else $error("counter did not reload");
   odd_ras_a: assert property (@(posedge clk) disable iff (!rstn)     // [R5]
      !cyc_busy && !$past(cyc_busy) && (ras_on & 8'hAA) != 8'h00
      |-> $past(sub_reg) && $past(two_sub_reg[bank_reg]))
      else $error("odd row strobe for single subbank");
endmodule : dar_top

// file: shared/dar_regs.svh
// Register offsets, field positions, reset values and timing counts for the
// DRAM address and refresh block. Assumes a word-wide register port.
// Operation
// R1: Row phase maps address bits 24,25,22..13 onto pins
// R2: Column phase maps 24,24,23,12..4 onto pins
// R3: Column strobe index equals little-endian byte number
// R4: Two row strobes per bank, pairs 1:0..7:6
// R5: Odd row strobe only for two-subbank banks; refresh bursts drive the odd strobes of all four banks
// R6: Refresh is CAS-before-RAS, no row address
// R7: Refresh bursts, rows and interval programmable
// R8: Burst setting covers four or eight rows
// R9: Stagger row strobes, four then four three later
// R10: Down-counter loads preload, reaches zero, reloads
// R11: Each rollover raises refresh request to arbiter
// R12: Start refresh only after arbiter grant
// R13: Burst refreshes exactly programmed rows per burst
// R14: Each rollover pulses watchdog increment
// R15: Row strobe one cycle, column strobe two after
// R16: Column strobe leads row strobe by lead count
// R17: Column strobe low after row strobe for count
// R18: Row strobe stays high for precharge count
// R19: Request held until grant, dropped once burst starts
`ifndef DAR_REGS_SVH
`define DAR_REGS_SVH
`define DAR_ADDR_PRELOAD     4'h0
`define DAR_ADDR_BURST       4'h1
`define DAR_ADDR_TIMING      4'h2
`define DAR_ADDR_BANKCFG     4'h3
`define DAR_ADDR_STATUS      4'h4
`define DAR_ADDR_COUNT       4'h5
`define DAR_PRELOAD_RST      16'h060E
`define DAR_ROWS_RST         4'h4
`define DAR_LEAD_RST         4'h2
`define DAR_CASLOW_RST       4'h4
`define DAR_RASCAS_RST       4'h2
`define DAR_PRECH_RST        4'h3
`define DAR_STAGGER_CYC      4'h3
`define DAR_TIM_LEAD_LSB     0
`define DAR_TIM_CASLOW_LSB   4
`define DAR_TIM_RASCAS_LSB   8
`define DAR_TIM_PRECH_LSB    12
`endif

// file: shared/dar_pkg.sv
// Types for the DRAM address and refresh block.
// Shared by the top module and its timing unit.
package dar_pkg;
   typedef enum logic [6:0] {
      DAR_IDLE  = 7'h01,
      DAR_WAIT  = 7'h02,
      DAR_LEAD  = 7'h04,
      DAR_RAS_A = 7'h08,
      DAR_RAS_B = 7'h10,
      DAR_HOLD  = 7'h20,
      DAR_PRE   = 7'h40
   } dar_ref_state_type;
   typedef enum logic [1:0] {
      DAR_PH_IDLE = 2'h1,
      DAR_PH_ROW  = 2'h2
   } dar_phase_type;
endpackage : dar_pkg

// file: design/dar_cycle.sv
// Refresh cycle sequencer: one CAS-before-RAS burst of a given row count.
// Assumes the caller starts it only while memory has been granted.
`timescale 1ns/1ps
`include "dar_regs.svh"
module dar_cycle
   import dar_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Control
   input  wire logic       start,
   input  wire logic [3:0] rows,
   input  wire logic [3:0] cas_lead_cycles,
   input  wire logic [3:0] refresh_cas_low_cycles,
   input  wire logic [3:0] refresh_ras_to_cas_cycles,
   input  wire logic [3:0] precharge_cycles,
   // Strobe requests
   output logic            ras_a_reg,
   output logic            ras_b_reg,
   output logic            cas_reg,
   output logic            busy_reg
);
   dar_ref_state_type state_reg;
   logic [3:0]        cnt_reg;
   logic [3:0]        rows_reg;

   function automatic logic [3:0] minus1(input logic [3:0] v);
      minus1 = (v == 4'h0) ? 4'h0 : v - 4'h1;
   endfunction : minus1

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= DAR_IDLE;
         cnt_reg   <= 4'h0;
         rows_reg  <= 4'h0;
      end else begin
         unique case (state_reg)
            DAR_IDLE: if (start && rows != 4'h0) begin
               rows_reg  <= rows;                              // [R13]
               cnt_reg   <= minus1(cas_lead_cycles);
               state_reg <= DAR_LEAD;
            end
            DAR_LEAD: if (cnt_reg == 4'h0) begin               // [R16]
               cnt_reg   <= minus1(`DAR_STAGGER_CYC);
               state_reg <= DAR_RAS_A;
            end else cnt_reg <= cnt_reg - 4'h1;
            DAR_RAS_A: if (cnt_reg == 4'h0) begin              // [R9]
               cnt_reg   <= minus1(refresh_cas_low_cycles);
               state_reg <= DAR_RAS_B;
            end else cnt_reg <= cnt_reg - 4'h1;
            DAR_RAS_B: if (cnt_reg == 4'h0) begin              // [R17]
               cnt_reg   <= minus1(refresh_ras_to_cas_cycles);
               state_reg <= DAR_HOLD;
            end else cnt_reg <= cnt_reg - 4'h1;
            DAR_HOLD: if (cnt_reg == 4'h0) begin
               cnt_reg   <= minus1(precharge_cycles);
               rows_reg  <= rows_reg - 4'h1;
               state_reg <= DAR_PRE;
            end else cnt_reg <= cnt_reg - 4'h1;
            DAR_PRE: if (cnt_reg == 4'h0) begin                // [R18]
               cnt_reg   <= minus1(cas_lead_cycles);
               state_reg <= (rows_reg == 4'h0) ? DAR_IDLE : DAR_LEAD;
            end else cnt_reg <= cnt_reg - 4'h1;
            default: state_reg <= DAR_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ras_a_reg <= 1'b0;
         ras_b_reg <= 1'b0;
         cas_reg   <= 1'b0;
         busy_reg  <= 1'b0;
      end else begin
         // Column strobe leads, row halves follow staggered by three cycles
         cas_reg   <= (state_reg == DAR_LEAD) || (state_reg == DAR_RAS_A)
                      || (state_reg == DAR_RAS_B);                    // [R6]
         ras_a_reg <= (state_reg == DAR_RAS_A) || (state_reg == DAR_RAS_B)
                      || (state_reg == DAR_HOLD);
         ras_b_reg <= (state_reg == DAR_RAS_B) || (state_reg == DAR_HOLD);
         busy_reg  <= (state_reg != DAR_IDLE) || (start && rows != 4'h0);
      end
   end

   // Second row group must follow exactly three cycles after the first
   sequence second_group_late;
      !ras_b_reg ##1 !ras_b_reg ##1 !ras_b_reg ##1 ras_b_reg;
   endsequence
   stagger_gap_a: assert property (@(posedge clk) disable iff (!rstn) // [R9]
      $rose(ras_a_reg) |-> second_group_late)
      else $error("second row group not three cycles late");
   cas_first_a: assert property (@(posedge clk) disable iff (!rstn)   // [R16]
      $rose(ras_a_reg) |-> $past(cas_reg))
      else $error("row strobe before column strobe in refresh");
endmodule : dar_cycle

// file: test/dar_simm_model.sv
// Passive model of the four SIMM banks: watches address and strobe pins.
// Assumes active-high strobe requests, all on the one block clock.
`timescale 1ns/1ps
module dar_simm_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // DRAM pins
   input  wire logic [11:0] mem_addr,
   input  wire logic [7:0]  ras_on,
   input  wire logic [15:0] cas_on,
   input  wire logic        refresh_busy,
   // Observations for the bench
   output logic             acc_seen,
   output logic [47:0]      acc_cap,
   output logic [7:0]       rows_seen,
   output logic [7:0]       bad_cnt
);
   logic [11:0] addr_d;
   logic [11:0] row_cap;
   logic [7:0]  ras_d;
   logic [7:0]  ras_cap;
   logic [15:0] cas_d;
   logic [1:0]  stg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {addr_d, row_cap, ras_d, ras_cap, cas_d, stg} <= '0;
         {acc_seen, acc_cap, rows_seen, bad_cnt} <= '0;
      end else begin
         addr_d   <= mem_addr;
         ras_d    <= ras_on;
         cas_d    <= cas_on;
         acc_seen <= 1'b0;
         // A DRAM latches the row on the address held before its strobe
         if (ras_on != 8'h00 && ras_d == 8'h00 && !refresh_busy) begin
            row_cap <= addr_d;
            ras_cap <= ras_on;
         end
         if (cas_on != 16'h0000 && cas_d == 16'h0000 && !refresh_busy) begin
            acc_cap  <= {row_cap, addr_d, ras_cap, cas_on};
            acc_seen <= 1'b1;
         end
         // Refresh rows: column strobes must already be low, even rows first
         if (refresh_busy && ras_on != 8'h00 && ras_d == 8'h00) begin
            rows_seen <= rows_seen + 8'h01;
            stg       <= 2'h1;
            if (cas_d != 16'hFFFF || ras_on != 8'h55 || mem_addr != 12'h000)
               bad_cnt <= bad_cnt + 8'h01;
         end else if (stg != 2'h0) begin
            stg <= (stg == 2'h3) ? 2'h0 : stg + 2'h1;
            if (ras_on != ((stg == 2'h3) ? 8'hFF : 8'h55))
               bad_cnt <= bad_cnt + 8'h01;
         end
      end
   end
endmodule : dar_simm_model

// file: test/dar_top_tb.sv
// Self-checking bench for the DRAM address and refresh block.
// The bench acts as register master, access source and arbiter.
`timescale 1ns/1ps
module dar_top_tb;
   logic        clk = 1'b0;
   logic        rstn, reg_wr, reg_rd, acc_req, acc_sub, refresh_grant;
   logic [3:0]  reg_addr, two_sub, n;
   logic [31:0] reg_wdata, reg_rdata;
   logic [25:0] acc_addr;
   logic [15:0] acc_bytes, cas_on;
   logic [1:0]  acc_bank;
   logic        refresh_req, start_refresh, wdog_inc, refresh_busy, acc_seen;
   logic        rd_d = 1'b0;
   logic [11:0] mem_addr;
   logic [7:0]  ras_on, rows_seen, bad_cnt, base;
   logic [47:0] acc_cap;
   logic [31:0] rq[$];
   logic [47:0] aq[$];
   int          error_cnt = 0, check_count = 0, cyc = 0, wd_last = 0, wd_gap = 0;

   always #20 clk = ~clk;

   dar_top dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .acc_req, .acc_addr, .acc_bytes, .acc_bank, .acc_sub, .refresh_grant,
      .refresh_req, .start_refresh, .wdog_inc, .mem_addr, .ras_on, .cas_on,
      .refresh_busy);
   dar_simm_model simm (.clk, .rstn, .mem_addr, .ras_on, .cas_on, .refresh_busy,
      .acc_seen, .acc_cap, .rows_seen, .bad_cnt);

   task automatic chk_val(input logic [47:0] got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic chk_reg(input logic [31:0] got, exp);
      chk_val({16'h0000, got}, {16'h0000, exp}, "register read");
   endtask : chk_reg

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   function automatic logic pick(input int w);
      case (w)
         0: return refresh_req;
         1: return start_refresh;
         2: return refresh_busy;
         default: return !refresh_busy;
      endcase
   endfunction : pick

   task automatic wait_hi(input int w, input int lim);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pick(w) !== 1'b1 && k < lim);
      if (pick(w) !== 1'b1) begin
         error_cnt++;
         $display("unexpected at %0t: wait %0d timed out", $time, w);
         final_report();
      end
   endtask : wait_hi

   // Each strobe is dropped and one idle edge passes, so calls chain safely
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      @(posedge clk);
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
      rq.push_back(e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
   endtask : reg_read

   task automatic access(input logic [1:0] b, input logic s);
      logic [25:0] a;
      logic [15:0] m;
      a = 26'($urandom);
      m = 16'($urandom) | 16'h8001;
      aq.push_back({a[24], a[25], a[22:13], a[24], a[24], a[23], a[12:4],
         8'h01 << {b, s & two_sub[b]}, m});
      acc_addr  <= a;
      acc_bytes <= m;
      acc_bank  <= b;
      acc_sub   <= s;
      acc_req   <= 1'b1;
      @(posedge clk);
      acc_req   <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : access

   // Result watcher: oldest note is taken whenever a result shows
   always @(posedge clk) begin
      cyc  <= cyc + 1;
      rd_d <= reg_rd;
      if (rd_d)
         chk_reg(reg_rdata, rq.pop_front());
      if (acc_seen)
         chk_val(acc_cap, aq.pop_front(), "access pins");
      if (wdog_inc) begin
         chk_val(48'(refresh_req), 48'h1, "request on rollover");
         wd_gap  <= cyc - wd_last;
         wd_last <= cyc;
      end
   end

   initial begin
      {rstn, reg_wr, reg_rd, acc_req, acc_sub, refresh_grant} = '0;
      {reg_addr, reg_wdata, acc_addr, acc_bytes, acc_bank} = '0;
      two_sub = 4'h0;
      void'($urandom(6018));
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      reg_read(4'h0, 32'h0000060E);
      reg_read(4'h1, 32'h00000004);
      reg_read(4'h2, 32'h00003242);
      reg_read(4'hF, 32'h00000000);
      two_sub = (4'($urandom) & 4'hE) | 4'h2;
      reg_write(4'h3, {28'h0000000, two_sub});
      reg_read(4'h3, {28'h0000000, two_sub});
      reg_write(4'h4, 32'hFFFFFFFF);
      reg_read(4'h4, 32'h00000000);
      $display("register test done");
      for (int i = 0; i < 8; i++)
         access(2'(i >> 1), i[0]);
      $display("address test done");
      reg_write(4'h0, 32'h00000096);
      for (int k = 0; k < 2; k++) begin
         n = k ? 4'h8 : 4'h4;
         reg_write(4'h1, {28'h0000000, n});
         wait_hi(0, 3000);
         reg_read(4'h5, 32'h00000095);
         reg_read(4'h4, 32'h00000001);
         base = rows_seen;
         repeat (3 + $urandom_range(6)) begin
            @(posedge clk);
            chk_val(48'({refresh_req, start_refresh}), 48'h2, "held request");
         end
         refresh_grant <= 1'b1;
         wait_hi(1, 10);
         chk_val(48'(refresh_req), 48'h0, "request withdrawn");
         refresh_grant <= 1'b0;
         wait_hi(2, 10);
         wait_hi(3, 600);
         chk_val(48'(rows_seen - base), 48'(n), "rows in burst");
      end
      chk_val(48'(wd_gap), 48'd151, "rollover interval");
      chk_val(48'(bad_cnt), 48'h0, "refresh strobe shape");
      $display("refresh test done");
      final_report();
   end
endmodule : dar_top_tb
